// [include/fip_pkg.sv]
// Package for the fast interrupt and protect logic block.
// Assumes a 32-bit APB register bus and a 40 MHz core clock.
package fip_pkg;
    localparam logic [11:0] OFF_SMR0 = 12'h000;
    localparam logic [11:0] OFF_SVR0 = 12'h080;
    localparam logic [11:0] OFF_IVR = 12'h100;
    localparam logic [11:0] OFF_FVR = 12'h104;
    localparam logic [11:0] OFF_ISR = 12'h108;
    localparam logic [11:0] OFF_IMR = 12'h110;
    localparam logic [11:0] OFF_IECR = 12'h120;
    localparam logic [11:0] OFF_IDCR = 12'h124;
    localparam logic [11:0] OFF_EOICR = 12'h130;
    localparam logic [11:0] OFF_SPU = 12'h134;
    localparam logic [11:0] OFF_DCR = 12'h138;
    localparam int PRIO_LSB = 0;
    localparam int PRIO_W = 3;
    localparam int STYPE_LSB = 5;
    localparam int STYPE_W = 2;
    localparam int DBG_PROT_BIT = 0;
    localparam int DBG_GLOBAL_MASK_BIT_BIT = 1;
    localparam int FAST_BIT = 0;
    localparam int ID_W = 5;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [ID_W-1:0] FAST_SRC_ID = 5'h00;

    // Source type encodings for source 0
    localparam logic [1:0] ST_LOW_LEVEL = 2'h0;
    localparam logic [1:0] ST_FALL_EDGE = 2'h1;
    localparam logic [1:0] ST_HIGH_LEVEL = 2'h2;
    localparam logic [1:0] ST_RISE_EDGE = 2'h3;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic valid;
        logic [ID_W-1:0] id;
        logic [PRIO_W-1:0] prio;
        logic [31:0] vector;
    } normal_irq_t;
endpackage

// [hdl/fast_interrupt_protect_logic.sv]
// Fast interrupt path, protect mode, spurious vector and general mask.
// Assumes an APB master on core_clk; the normal priority resolver and its
// stack sit outside and talk through the irq_* and stack/ack strobes.
//
// What this block does
// - Only source 0 can raise the fast request line.
// - Fast path has no arbitration; source 0 priority field only stored.
// - Source 0 type field picks rising, falling, high or low detection.
// - Enable command bit 0 enables fast interrupt; disable command disables it.
// - Enable mask bit 0 shows fast interrupt enable state.
// - Fast vector read returns source 0 vector register.
// - Fast vector read clears pending edge fast interrupt, not level one.
// - Fast vector read with nothing pending returns the spurious vector.
// - Protect mode bit set enables protect mode; cleared means normal mode.
// - Normal mode vector read returns, memorizes, pushes and acknowledges.
// - Protect mode vector read only returns and memorizes; write pushes.
// - Protect mode status updates to memorized interrupt only on write.
// - Protect mode reads alone never change context or status.
// - Normal mode vector register write has no effect.
// - Vector read with nothing pending returns the spurious vector.
// - Global mask holds both request lines inactive.
// - Global mask does not suppress idle wake-up.
`timescale 1ns/1ps
`default_nettype none
module fast_interrupt_protect_logic (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_source_pin,
    input wire fip_pkg::normal_irq_t normal_irq,
    input wire logic normal_raise,
    output logic fast_request_line_n,
    output logic normal_request_line_n,
    output logic wake_up,
    output logic stack_push,
    output logic irq_ack,
    output logic [fip_pkg::ID_W-1:0] ack_id,
    output logic end_of_service
);
    import fip_pkg::*;

    logic [31:0] source0_mode_reg_r;
    logic [31:0] source0_vector_reg_r;
    logic [31:0] spurious_vector_reg_r;
    logic [1:0] debug_control_reg_r;
    logic fast_enable_r;
    logic fast_pending_r;
    logic [2:0] pin_sync_r;
    logic pin_prev_r;
    logic [ID_W-1:0] current_id_r;
    logic memo_valid_r;
    logic [ID_W-1:0] memo_id_r;
    logic [31:0] prdata_r;
    logic fiq_n_r;
    logic irq_n_r;
    logic stack_push_r;
    logic irq_ack_r;
    logic [ID_W-1:0] ack_id_r;
    logic eos_r;

    logic access;
    logic wr;
    logic rd;
    logic pin_stable;
    logic [1:0] stype;
    logic is_edge;
    logic edge_hit;
    logic level_act;
    logic protect;
    logic gmask;
    logic fvr_read;
    logic ivr_read;
    logic ivr_write;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_r;
    assign protect = debug_control_reg_r[DBG_PROT_BIT];
    assign gmask = debug_control_reg_r[DBG_GLOBAL_MASK_BIT_BIT];
    assign stype = source0_mode_reg_r[STYPE_LSB +: STYPE_W];
    assign is_edge = stype[0];
    assign fvr_read = rd && hit(paddr, OFF_FVR);
    assign ivr_read = rd && hit(paddr, OFF_IVR);
    assign ivr_write = wr && hit(paddr, OFF_IVR);

    // Pin sync, change counted when stages 2 and 3 agree
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_sync_r <= 3'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], fast_source_pin};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_prev_r <= 1'b0;
        end else if (pin_sync_r[1] == pin_sync_r[2]) begin
            pin_prev_r <= pin_sync_r[2];
        end
    end

    assign pin_stable = (pin_sync_r[1] == pin_sync_r[2]) ? pin_sync_r[2] : pin_prev_r;

    // Edge and level detect per source type
    always_comb begin
        edge_hit = 1'b0;
        level_act = 1'b0;
        case (stype)
            ST_RISE_EDGE: edge_hit = pin_stable && !pin_prev_r;
            ST_FALL_EDGE: edge_hit = !pin_stable && pin_prev_r;
            ST_HIGH_LEVEL: level_act = pin_stable;
            ST_LOW_LEVEL: level_act = !pin_stable;
            default: level_act = 1'b0;
        endcase
    end

    // Edge pending flag, set wins over the read clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fast_pending_r <= 1'b0;
        end else if (!is_edge) begin
            fast_pending_r <= 1'b0;
        end else if (edge_hit) begin
            fast_pending_r <= 1'b1;
        end else if (fvr_read) begin
            fast_pending_r <= 1'b0;
        end
    end

    // Register writes; priority field stored only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            source0_mode_reg_r <= RESET_WORD;
            source0_vector_reg_r <= RESET_WORD;
            spurious_vector_reg_r <= RESET_WORD;
            debug_control_reg_r <= 2'h0;
            fast_enable_r <= 1'b0;
        end else if (wr) begin
            if (hit(paddr, OFF_SMR0)) begin
                source0_mode_reg_r <= pwdata & 32'h0000_0067;
            end
            if (hit(paddr, OFF_SVR0)) begin
                source0_vector_reg_r <= pwdata;
            end
            if (hit(paddr, OFF_SPU)) begin
                spurious_vector_reg_r <= pwdata;
            end
            if (hit(paddr, OFF_DCR)) begin
                debug_control_reg_r <= pwdata[1:0];
            end
            if (hit(paddr, OFF_IECR) && pwdata[FAST_BIT]) begin
                fast_enable_r <= 1'b1;
            end
            if (hit(paddr, OFF_IDCR) && pwdata[FAST_BIT]) begin
                fast_enable_r <= 1'b0;
            end
        end
    end

    // Memorize active interrupt on every vector read
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            memo_valid_r <= 1'b0;
            memo_id_r <= FAST_SRC_ID;
        end else if (ivr_read) begin
            memo_valid_r <= normal_irq.valid;
            memo_id_r <= normal_irq.id;
        end else if (protect && ivr_write) begin
            // One write consumes the memorized interrupt, no double push
            memo_valid_r <= 1'b0;
        end
    end

    // Push, acknowledge and context update
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stack_push_r <= 1'b0;
            irq_ack_r <= 1'b0;
            ack_id_r <= FAST_SRC_ID;
            current_id_r <= FAST_SRC_ID;
            eos_r <= 1'b0;
        end else begin
            stack_push_r <= 1'b0;
            irq_ack_r <= 1'b0;
            eos_r <= wr && hit(paddr, OFF_EOICR);
            if (!protect && ivr_read && normal_irq.valid) begin
                stack_push_r <= 1'b1;
                irq_ack_r <= 1'b1;
                ack_id_r <= normal_irq.id;
                current_id_r <= normal_irq.id;
            end else if (protect && ivr_write && memo_valid_r) begin
                stack_push_r <= 1'b1;
                irq_ack_r <= 1'b1;
                ack_id_r <= memo_id_r;
                current_id_r <= memo_id_r;
            end
        end
    end

    // Read data mux
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= RESET_WORD;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFF_SMR0: prdata_r <= source0_mode_reg_r;
                OFF_SVR0: prdata_r <= source0_vector_reg_r;
                // Spurious when nothing pending
                OFF_IVR: prdata_r <= normal_irq.valid ? normal_irq.vector
                                                      : spurious_vector_reg_r;
                // Fast vector or spurious
                OFF_FVR: prdata_r <= (fast_enable_r && (fast_pending_r || level_act))
                                     ? source0_vector_reg_r : spurious_vector_reg_r;
                OFF_ISR: prdata_r <= {27'h0, current_id_r};
                OFF_IMR: prdata_r <= {31'h0, fast_enable_r};
                OFF_SPU: prdata_r <= spurious_vector_reg_r;
                OFF_DCR: prdata_r <= {30'h0, debug_control_reg_r};
                default: prdata_r <= RESET_WORD;
            endcase
        end
    end

    // Registered active-low request lines, gated by global mask
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fiq_n_r <= 1'b1;
            irq_n_r <= 1'b1;
        end else begin
            fiq_n_r <= !(fast_enable_r && !gmask && (fast_pending_r || level_act));
            irq_n_r <= !(normal_raise && !gmask);
        end
    end

    assign fast_request_line_n = fiq_n_r;
    assign normal_request_line_n = irq_n_r;
    // Wake ignores the global mask
    assign wake_up = (fast_enable_r && (fast_pending_r || level_act)) || normal_raise;
    assign stack_push = stack_push_r;
    assign irq_ack = irq_ack_r;
    assign ack_id = ack_id_r;
    assign end_of_service = eos_r;

    fast_mask_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $past(gmask) |-> (fast_request_line_n && normal_request_line_n))
        else $error("request asserted under global mask");
    fast_disabled_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !$past(fast_enable_r) |-> fast_request_line_n)
        else $error("fast request while disabled");
    protect_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (protect && !ivr_write) |=> !stack_push && $stable(current_id_r))
        else $error("context changed by protect read");
    normal_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (!protect && ivr_write && !ivr_read) |=> !irq_ack)
        else $error("write acted in normal mode");
    normal_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (!protect && ivr_read && normal_irq.valid) |=> stack_push && irq_ack)
        else $error("normal read did not push");
    protect_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (protect && ivr_write && memo_valid_r) |=> irq_ack && current_id_r == $past(memo_id_r))
        else $error("protect write did not update");
    edge_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (fvr_read && !edge_hit) |=> !fast_pending_r)
        else $error("edge pending not cleared");
    imr_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (psel && !penable && !pwrite && paddr == OFF_IMR) |=> prdata[0] == $past(fast_enable_r))
        else $error("mask bit mismatch");
endmodule
`default_nettype wire

// [testbench/resolver_model.sv]
// Stand-in for the normal priority resolver facing the block.
// Assumes the bench picks the active interrupt; counts the block's strobes.
`timescale 1ns/1ps
`default_nettype none
module resolver_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic act_valid,
    input wire logic [fip_pkg::ID_W-1:0] act_id,
    input wire logic [31:0] act_vec,
    input wire logic stack_push,
    input wire logic irq_ack,
    input wire logic end_of_service,
    output var fip_pkg::normal_irq_t normal_irq,
    output var int push_cnt,
    output var int ack_cnt,
    output var int eos_cnt
);
    import fip_pkg::*;
    assign normal_irq = {act_valid, act_id, 3'h4, act_vec};
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            push_cnt <= 0;
            ack_cnt <= 0;
            eos_cnt <= 0;
        end else begin
            push_cnt <= push_cnt + int'(stack_push === 1'b1);
            ack_cnt <= ack_cnt + int'(irq_ack === 1'b1);
            eos_cnt <= eos_cnt + int'(end_of_service === 1'b1);
        end
    end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the fast interrupt and protect block.
// Assumes fip_pkg and resolver_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
    import fip_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, fast_request_line_n, normal_request_line_n, wake_up;
    logic stack_push, irq_ack, end_of_service;
    logic [ID_W-1:0] ack_id;
    logic fast_source_pin = 1'b1;
    logic normal_raise = 1'b0;
    logic act_valid = 1'b0;
    logic [ID_W-1:0] act_id = 5'h00;
    logic [31:0] act_vec = 32'h0;
    normal_irq_t normal_irq;
    int push_cnt, ack_cnt, eos_cnt, p0, a0;
    int errors = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic [1:0] types [4] = '{ST_RISE_EDGE, ST_HIGH_LEVEL, ST_FALL_EDGE, ST_LOW_LEVEL};
    logic idle_lvl [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

    always #12.5 core_clk = ~core_clk;

    fast_interrupt_protect_logic i_dut (.core_clk(core_clk), .resetn(resetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_source_pin(fast_source_pin), .normal_irq(normal_irq),
        .normal_raise(normal_raise), .fast_request_line_n(fast_request_line_n),
        .normal_request_line_n(normal_request_line_n), .wake_up(wake_up),
        .stack_push(stack_push), .irq_ack(irq_ack), .ack_id(ack_id),
        .end_of_service(end_of_service));
    resolver_model i_resolver (.core_clk(core_clk), .resetn(resetn), .act_valid(act_valid),
        .act_id(act_id), .act_vec(act_vec), .stack_push(stack_push), .irq_ack(irq_ack),
        .end_of_service(end_of_service), .normal_irq(normal_irq), .push_cnt(push_cnt),
        .ack_cnt(ack_cnt), .eos_cnt(eos_cnt));

    task automatic final_report();
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            final_report();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic wait_fast(input logic v);
        int n;
        n = 0;
        while (fast_request_line_n !== v && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(fast_request_line_n, v)
        if (n >= 20) begin
            final_report();
        end
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        `CHK({fast_request_line_n, normal_request_line_n}, 2'b11)
        resetn <= 1'b1;
        rd_chk(OFF_DCR, 32'h0);
        rd_chk(OFF_IMR, 32'h0);
        rd_chk(12'h118, 32'h0);
        apb(1'b1, OFF_SVR0, 32'h0000_2a40);
        apb(1'b1, OFF_SPU, 32'h0000_5c80);
        fast_source_pin <= 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK(fast_request_line_n, 1'b1)
        rd_chk(OFF_FVR, 32'h0000_5c80);
        fast_source_pin <= 1'b1;
        apb(1'b1, OFF_IECR, 32'h1);
        rd_chk(OFF_IMR, 32'h1);
        apb(1'b1, OFF_IDCR, 32'h1);
        rd_chk(OFF_IMR, 32'h0);
        apb(1'b1, OFF_IECR, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_SMR0, {25'h0, types[i], 2'b00, 3'h5});
            rd_chk(OFF_SMR0, {25'h0, types[i], 2'b00, 3'h5});
            fast_source_pin <= idle_lvl[i];
            repeat (8) @(negedge core_clk);
            `CHK(fast_request_line_n, 1'b1)
            @(posedge core_clk);
            fast_source_pin <= ~idle_lvl[i];
            wait_fast(1'b0);
            rd_chk(OFF_FVR, 32'h0000_2a40);
            repeat (3) @(negedge core_clk);
            `CHK(fast_request_line_n, types[i][0])
            @(posedge core_clk);
            fast_source_pin <= idle_lvl[i];
            wait_fast(1'b1);
        end
        apb(1'b1, OFF_DCR, 32'h2);
        fast_source_pin <= 1'b0;
        normal_raise <= 1'b1;
        repeat (10) @(negedge core_clk);
        `CHK({fast_request_line_n, normal_request_line_n}, 2'b11)
        `CHK(wake_up, 1'b1)
        apb(1'b1, OFF_DCR, 32'h0);
        wait_fast(1'b0);
        `CHK(normal_request_line_n, 1'b0)
        @(posedge core_clk);
        fast_source_pin <= 1'b1;
        act_valid <= 1'b1;
        act_id <= 5'h03;
        act_vec <= 32'h0000_3100;
        wait_fast(1'b1);
        p0 = push_cnt;
        a0 = ack_cnt;
        rd_chk(OFF_IVR, 32'h0000_3100);
        repeat (2) @(negedge core_clk);
        `CHK({push_cnt, ack_cnt}, {p0 + 1, a0 + 1})
        apb(1'b1, OFF_IVR, 32'hffff_ffff);
        repeat (2) @(negedge core_clk);
        `CHK({push_cnt, ack_cnt}, {p0 + 1, a0 + 1})
        rd_chk(OFF_ISR, 32'h3);
        apb(1'b1, OFF_DCR, 32'h1);
        rd_chk(OFF_DCR, 32'h1);
        act_id <= 5'h09;
        act_vec <= 32'h0000_3900;
        repeat (2) rd_chk(OFF_IVR, 32'h0000_3900);
        repeat (2) @(negedge core_clk);
        `CHK({push_cnt, ack_cnt}, {p0 + 1, a0 + 1})
        rd_chk(OFF_ISR, 32'h3);
        apb(1'b1, OFF_IVR, 32'h0);
        repeat (2) @(negedge core_clk);
        `CHK({push_cnt, ack_cnt}, {p0 + 2, a0 + 2})
        `CHK(ack_id, 5'h09)
        rd_chk(OFF_ISR, 32'h9);
        apb(1'b1, OFF_IVR, 32'h0);
        repeat (2) @(negedge core_clk);
        `CHK({push_cnt, ack_cnt}, {p0 + 2, a0 + 2})
        apb(1'b1, OFF_DCR, 32'h0);
        act_valid <= 1'b0;
        rd_chk(OFF_IVR, 32'h0000_5c80);
        apb(1'b1, OFF_EOICR, 32'h0);
        repeat (2) @(negedge core_clk);
        `CHK(eos_cnt, 1)
        final_report();
    end
endmodule
`default_nettype wire
